//--- dsr_pkg.sv
package dsr_pkg;
    // =====================================================
    // geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;
    // =====================================================
    // command mode register select on addr[2:0]
    localparam logic [2:0] CMD_START1 = 3'h0;
    localparam logic [2:0] CMD_END1 = 3'h1;
    localparam logic [2:0] CMD_START2 = 3'h2;
    localparam logic [2:0] CMD_END2 = 3'h3;
    localparam logic [2:0] CMD_FLOW = 3'h4;
    localparam logic [2:0] CMD_FLAGS = 3'h5;
    // flow register fields and flag clear bits
    localparam int FLOW1_LSB = 0;
    localparam int FLOW2_LSB = 2;
    localparam int CLR1_BIT = 0;
    localparam int CLR2_BIT = 1;
    // address read-back pattern on cmd_rd bits 15:12; the port returns only its bit 12, with bits 15:13 zero
    localparam logic [3:0] ADDR_RD_TOP = 4'hE;
    // =====================================================
    // reset values
    localparam logic [11:0] RST_PTR = 12'h000;
    localparam logic [11:0] RST_START1 = 12'h000;
    localparam logic [11:0] RST_END1 = 12'hFFF;
    localparam logic [11:0] RST_START2 = 12'h000;
    localparam logic [11:0] RST_END2 = 12'h000;
    localparam logic [3:0] RST_FLOW = 4'h0;
    // =====================================================
    // per-buffer flow mode at its end address
    typedef enum logic [1:0] {
        DSR_FLOW_CHAIN = 2'b00,
        DSR_FLOW_WRAP = 2'b01,
        DSR_FLOW_STOP = 2'b10,
        DSR_FLOW_LINEAR = 2'b11
    } dsr_flow_t;
    // =====================================================
    // pin groups and fifo word
    typedef struct packed {
        logic sel_n;
        logic cmd_n;
        logic wnr;
        logic oe_n;
        logic lb_n;
        logic ub_n;
        logic [11:0] addr;
        logic [15:0] data;
    } dsr_rnd_pins_t;
    typedef struct packed {
        logic clk;
        logic sel_n;
        logic adv_n;
        logic wnr;
        logic oe_n;
        logic [15:0] data;
    } dsr_seq_pins_t;
    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] data;
    } dsr_seq_wr_t;
endpackage : dsr_pkg

//--- dsr_ports.sv
// Functional notes
// - random read drives selected byte lanes only
// - random write stores selected byte lanes only
// - select and command high: float, power down
// - output enable high: float, no power down
// - both byte selects high: no access
// - command write stores low twelve bits
// - command read returns register on low bits
// - command accesses honour single byte lanes
// - advancing read outputs word, advances counter
// - non-advancing read holds pointer, word, flags
// - reaching buffer end drives its flag low
// - output enable high floats, still advances
// - write edge stores word, advances if enabled
// - non-advancing write keeps pointer and flags
// - deselected, no advance: idle, float, hold
// - deselected with advance: counter and flags move
// - write ends when direction or select high
// - counter increments before that cycle's operation
// - control reset clears pointer, flags, config asynchronously
`timescale 1ns/1ns
`default_nettype none

// =====================================================
// fifo
module dsr_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [PW:0] count, next_count;
    logic push, pop;

    assign in_ready_o = (count != (PW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = store[rd_ptr];

    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = (PW+1)'(count + push - pop);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            store[wr_ptr] <= in_data_i;
        end
    end
endmodule : dsr_fifo

// =====================================================
// top
module dsr_ports (
    // clock and resets
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ctrl_reset_n_i,
    // random port
    input wire dsr_pkg::dsr_rnd_pins_t rnd_i,
    output logic [15:0] rnd_data_o,
    output logic [1:0] rnd_data_oe_n_o,
    output logic rnd_power_down_o,
    // sequential port
    input wire dsr_pkg::dsr_seq_pins_t seq_i,
    output logic [15:0] seq_data_o,
    output logic seq_data_oe_n_o,
    output logic buffer_one_end_flag_n_o,
    output logic buffer_two_end_flag_n_o,
    output logic seq_wr_ready_o
);
    // =====================================================
    // synchronisers
    dsr_pkg::dsr_rnd_pins_t rnd_s1, rs;
    dsr_pkg::dsr_seq_pins_t seq_s1, ss;
    logic sclk_d;
    logic cfg_arst_n;

    // control reset acts without the clock
    assign cfg_arst_n = arst_n_i && ctrl_reset_n_i;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rnd_s1 <= '1;
            rs <= '1;
            seq_s1 <= '1;
            ss <= '1;
            sclk_d <= 1'b1;
        end else begin
            rnd_s1 <= rnd_i;
            rs <= rnd_s1;
            seq_s1 <= seq_i;
            ss <= seq_s1;
            sclk_d <= ss.clk;
        end
    end

    // =====================================================
    // storage and write fifo
    logic [15:0] mem [1<<dsr_pkg::ADDR_W];
    dsr_pkg::dsr_seq_wr_t push_word, pop_word;
    logic push_valid, fifo_ready, pop_valid, pop_ready;
    logic [1:0] rnd_we;

    dsr_fifo #(.WIDTH($bits(dsr_pkg::dsr_seq_wr_t)), .DEPTH(dsr_pkg::FIFO_DEPTH)) u_wr_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(push_valid),
        .in_ready_o(fifo_ready),
        .in_data_i(push_word),
        .out_valid_o(pop_valid),
        .out_ready_i(pop_ready),
        .out_data_o(pop_word)
    );

    // random writes own the array; streamed words wait in the fifo
    assign pop_ready = (rnd_we == 2'b00);

    always_ff @(posedge clk_i) begin
        if (rnd_we[0]) begin
            mem[rs.addr][7:0] <= rs.data[7:0];
        end
        if (rnd_we[1]) begin
            mem[rs.addr][15:8] <= rs.data[15:8];
        end
        if (pop_ready && pop_valid) begin
            mem[pop_word.addr] <= pop_word.data;
        end
    end

    // =====================================================
    // random port
    logic mem_sel, cmd_sel;
    logic [1:0] lanes, next_oe_n;
    logic [15:0] next_rdata, cmd_rd;
    logic [11:0] start1, end1, start2, end2;
    logic [3:0] flow;
    logic buffer_one_end_flag_n_n, buffer_two_end_flag_n_n;

    always_comb begin
        mem_sel = !rs.sel_n && rs.cmd_n;
        cmd_sel = rs.sel_n && !rs.cmd_n;
        lanes = {!rs.ub_n, !rs.lb_n};
        rnd_we = (mem_sel && !rs.wnr) ? lanes : 2'b00;
        unique case (rs.addr[2:0])
            dsr_pkg::CMD_START1: cmd_rd = {dsr_pkg::ADDR_RD_TOP, start1};
            dsr_pkg::CMD_END1: cmd_rd = {dsr_pkg::ADDR_RD_TOP, end1};
            dsr_pkg::CMD_START2: cmd_rd = {dsr_pkg::ADDR_RD_TOP, start2};
            dsr_pkg::CMD_END2: cmd_rd = {dsr_pkg::ADDR_RD_TOP, end2};
            dsr_pkg::CMD_FLOW: cmd_rd = {12'h000, flow};
            dsr_pkg::CMD_FLAGS: cmd_rd = {14'h0000, !buffer_two_end_flag_n_n, !buffer_one_end_flag_n_n};
            default: cmd_rd = 16'h0000;
        endcase
        next_oe_n = 2'b11;
        next_rdata = rnd_data_o;
        if ((mem_sel || cmd_sel) && rs.wnr && !rs.oe_n) begin
            next_oe_n = ~lanes;
            next_rdata = mem_sel ? mem[rs.addr] : {3'b000, cmd_rd[12:0]};
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rnd_data_o <= 16'h0000;
            rnd_data_oe_n_o <= 2'b11;
            rnd_power_down_o <= 1'b1;
        end else begin
            rnd_data_o <= next_rdata;
            rnd_data_oe_n_o <= next_oe_n;
            rnd_power_down_o <= rs.sel_n && rs.cmd_n;
        end
    end

    // =====================================================
    // buffer configuration
    logic cmd_wr;
    logic [11:0] next_start1, next_end1, next_start2, next_end2, lane_val;
    logic [3:0] next_flow;
    logic [1:0] flag_clr;

    always_comb begin
        cmd_wr = cmd_sel && !rs.wnr;
        lane_val = 12'h000;
        next_start1 = start1;
        next_end1 = end1;
        next_start2 = start2;
        next_end2 = end2;
        next_flow = flow;
        flag_clr = 2'b00;
        if (cmd_wr) begin
            unique case (rs.addr[2:0])
                dsr_pkg::CMD_START1: lane_val = start1;
                dsr_pkg::CMD_END1: lane_val = end1;
                dsr_pkg::CMD_START2: lane_val = start2;
                dsr_pkg::CMD_END2: lane_val = end2;
                default: lane_val = {8'h00, flow};
            endcase
            if (lanes[0]) lane_val[7:0] = rs.data[7:0];
            if (lanes[1]) lane_val[11:8] = rs.data[11:8];
            unique case (rs.addr[2:0])
                dsr_pkg::CMD_START1: next_start1 = lane_val;
                dsr_pkg::CMD_END1: next_end1 = lane_val;
                dsr_pkg::CMD_START2: next_start2 = lane_val;
                dsr_pkg::CMD_END2: next_end2 = lane_val;
                dsr_pkg::CMD_FLOW: next_flow = lane_val[3:0];
                dsr_pkg::CMD_FLAGS: flag_clr = lanes[0] ?
                    {rs.data[dsr_pkg::CLR2_BIT], rs.data[dsr_pkg::CLR1_BIT]} : 2'b00;
                default: flag_clr = 2'b00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge cfg_arst_n) begin
        if (!cfg_arst_n) begin
            start1 <= dsr_pkg::RST_START1;
            end1 <= dsr_pkg::RST_END1;
            start2 <= dsr_pkg::RST_START2;
            end2 <= dsr_pkg::RST_END2;
            flow <= dsr_pkg::RST_FLOW;
        end else begin
            start1 <= next_start1;
            end1 <= next_end1;
            start2 <= next_start2;
            end2 <= next_end2;
            flow <= next_flow;
        end
    end

    // =====================================================
    // sequential port
    logic sedge, adv, last_rd, next_last_rd, next_buffer_one_end_flag_n_n, next_buffer_two_end_flag_n_n;
    logic [11:0] ptr, next_ptr, step, op_addr;
    logic [15:0] next_sdata;
    dsr_pkg::dsr_flow_t mode1, mode2;

    always_comb begin
        sedge = ss.clk && !sclk_d;
        adv = !ss.adv_n;
        mode1 = dsr_pkg::dsr_flow_t'(flow[dsr_pkg::FLOW1_LSB +: 2]);
        mode2 = dsr_pkg::dsr_flow_t'(flow[dsr_pkg::FLOW2_LSB +: 2]);
        step = 12'(ptr + 12'h001);
        if (ptr == end1) begin
            unique case (mode1)
                dsr_pkg::DSR_FLOW_CHAIN: step = start2;
                dsr_pkg::DSR_FLOW_WRAP: step = start1;
                dsr_pkg::DSR_FLOW_STOP: step = ptr;
                dsr_pkg::DSR_FLOW_LINEAR: step = 12'(ptr + 12'h001);
            endcase
        end else if (ptr == end2) begin
            unique case (mode2)
                dsr_pkg::DSR_FLOW_CHAIN: step = start1;
                dsr_pkg::DSR_FLOW_WRAP: step = start2;
                dsr_pkg::DSR_FLOW_STOP: step = ptr;
                dsr_pkg::DSR_FLOW_LINEAR: step = 12'(ptr + 12'h001);
            endcase
        end
        // increment first, then the access uses the new address
        op_addr = adv ? step : ptr;
        next_ptr = ptr;
        next_buffer_one_end_flag_n_n = buffer_one_end_flag_n_n || flag_clr[0];
        next_buffer_two_end_flag_n_n = buffer_two_end_flag_n_n || flag_clr[1];
        next_sdata = seq_data_o;
        next_last_rd = last_rd;
        push_valid = 1'b0;
        push_word = '{addr: op_addr, data: ss.data};
        if (sedge) begin
            if (adv) begin
                next_ptr = op_addr;
                if (op_addr == end1) next_buffer_one_end_flag_n_n = 1'b0;
                if (op_addr == end2) next_buffer_two_end_flag_n_n = 1'b0;
            end
            next_last_rd = !ss.sel_n && ss.wnr;
            if (!ss.sel_n && ss.wnr && adv) next_sdata = mem[op_addr];
            push_valid = !ss.sel_n && !ss.wnr;
        end
    end

    always_ff @(posedge clk_i or negedge cfg_arst_n) begin
        if (!cfg_arst_n) begin
            ptr <= dsr_pkg::RST_PTR;
            buffer_one_end_flag_n_o <= 1'b1;
            buffer_two_end_flag_n_o <= 1'b1;
            last_rd <= 1'b0;
        end else begin
            ptr <= next_ptr;
            buffer_one_end_flag_n_o <= next_buffer_one_end_flag_n_n;
            buffer_two_end_flag_n_o <= next_buffer_two_end_flag_n_n;
            last_rd <= next_last_rd;
        end
    end
    assign buffer_one_end_flag_n_n = buffer_one_end_flag_n_o;
    assign buffer_two_end_flag_n_n = buffer_two_end_flag_n_o;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seq_data_o <= 16'h0000;
            seq_data_oe_n_o <= 1'b1;
            seq_wr_ready_o <= 1'b0;
        end else begin
            seq_data_o <= next_sdata;
            seq_data_oe_n_o <= !(next_last_rd && !ss.oe_n);
            seq_wr_ready_o <= fifo_ready;
        end
    end

    // =====================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!cfg_arst_n);

    sequence s_mem_rd_lo;
        !rs.sel_n && rs.cmd_n && rs.wnr && !rs.oe_n && !rs.lb_n;
    endsequence
    sequence s_adv_edge;
        sedge && adv;
    endsequence

    chk_rnd_read_lane: assert property (s_mem_rd_lo |=> !rnd_data_oe_n_o[0])
        else $error("lower lane not driven on read");
    chk_rnd_write_byte: assert property (rnd_we[0] |=> mem[$past(rs.addr)][7:0] == $past(rs.data[7:0]))
        else $error("lower byte not written");
    chk_rnd_deselect_pd: assert property (rs.sel_n && rs.cmd_n
        |=> rnd_data_oe_n_o == 2'b11 && rnd_power_down_o)
        else $error("deselect did not float and power down");
    chk_rnd_oe_off: assert property (!rs.sel_n && rs.oe_n |=> rnd_data_oe_n_o == 2'b11 && !rnd_power_down_o)
        else $error("outputs not disabled");
    chk_rnd_no_lane: assert property (!rs.sel_n && rs.ub_n && rs.lb_n
        |-> rnd_we == 2'b00 ##1 rnd_data_oe_n_o == 2'b11)
        else $error("access with no byte selected");
    chk_cmd_write_start: assert property (cmd_wr && lanes == 2'b11 && rs.addr[2:0] == 3'h0
        |=> start1 == $past(rs.data[11:0]))
        else $error("start address not stored");
    chk_cmd_read_end: assert property (cmd_sel && rs.wnr && !rs.oe_n && !rs.lb_n && rs.addr[2:0] == 3'h1
        |=> rnd_data_o[12:0] == {1'b0, end1})
        else $error("end address not returned");
    chk_seq_adv_ptr: assert property (s_adv_edge |=> ptr == $past(op_addr) && $past(op_addr) == $past(step))
        else $error("pointer did not advance");
    chk_seq_hold_ptr: assert property (sedge && !adv && !flag_clr[0] |=> $stable(ptr) && $stable(buffer_one_end_flag_n_n))
        else $error("pointer or flag moved without advance");
    chk_seq_end_flag: assert property ((s_adv_edge and (step == end1)) |=> !buffer_one_end_flag_n_o)
        else $error("end flag not set");
    chk_seq_float: assert property (sedge && ss.sel_n |=> seq_data_oe_n_o)
        else $error("bus driven while deselected");
    chk_seq_push: assert property (sedge && !ss.sel_n && !ss.wnr
        |-> push_valid && push_word.addr == op_addr)
        else $error("write word not queued");
endmodule : dsr_ports
`default_nettype wire

//--- dsr_seq_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========
// streaming controller on the sequential pins
module dsr_seq_model (
    // clock
    input wire logic clk_i,
    // pins toward the device
    output var dsr_pkg::dsr_seq_pins_t seq_o
);
    initial seq_o = {1'b0, 4'hF, 16'h0000};

    // c is {sel_n, adv_n, wnr, oe_n}; clock stands low between steps
    task automatic step(input logic [3:0] c, input logic [15:0] d);
        @(negedge clk_i);
        seq_o.sel_n = c[3];
        seq_o.adv_n = c[2];
        seq_o.wnr = c[1];
        // output stays off ahead of any write edge
        seq_o.oe_n = c[0] | ~c[1];
        // released bus shows the inverse, never a stale word
        seq_o.data = c[1] ? ~seq_o.data : d;
        repeat (2) @(negedge clk_i);
        seq_o.clk = 1'b1;
        repeat (3) @(negedge clk_i);
        seq_o.clk = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask : step
endmodule : dsr_seq_model

`default_nettype wire

//--- dsr_ports_bench.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(what, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", what, e, g); end end

module dsr_ports_bench;
    typedef struct {
        string what;
        logic [38:0] exp;
        logic [38:0] msk;
    } dsr_note_t;
    // random port codes {sel_n, cmd_n, wnr, oe_n, lb_n, ub_n}
    localparam logic [5:0] RD = 6'h18;
    localparam logic [5:0] RDL = 6'h19;
    localparam logic [5:0] RDU = 6'h1A;
    localparam logic [5:0] RDO = 6'h1C;
    localparam logic [5:0] WR = 6'h14;
    localparam logic [5:0] WRL = 6'h15;
    localparam logic [5:0] WRN = 6'h17;
    localparam logic [5:0] IDLE = 6'h3F;
    localparam logic [5:0] CWR = 6'h24;
    localparam logic [5:0] CWL = 6'h25;
    localparam logic [5:0] CWU = 6'h26;
    localparam logic [5:0] CRD = 6'h28;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic ctrl_reset_n_i = 1'b1;
    logic look = 1'b0;
    dsr_pkg::dsr_rnd_pins_t rnd_i;
    wire dsr_pkg::dsr_seq_pins_t seq_i;
    wire logic [15:0] rnd_data_o;
    wire logic [15:0] seq_data_o;
    wire logic [1:0] rnd_data_oe_n_o;
    wire logic rnd_power_down_o;
    wire logic seq_data_oe_n_o;
    wire logic flag1_n;
    wire logic flag2_n;
    wire logic seq_wr_ready_o;
    wire logic [38:0] obs;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    dsr_note_t notes[$];
    logic [15:0] w [0:3];

    assign obs = {seq_wr_ready_o, rnd_data_oe_n_o, rnd_power_down_o, seq_data_oe_n_o, flag1_n, flag2_n,
                  rnd_data_o, seq_data_o};

    dsr_ports dut (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .ctrl_reset_n_i(ctrl_reset_n_i),
        .rnd_i(rnd_i),
        .rnd_data_o(rnd_data_o),
        .rnd_data_oe_n_o(rnd_data_oe_n_o),
        .rnd_power_down_o(rnd_power_down_o),
        .seq_i(seq_i),
        .seq_data_o(seq_data_o),
        .seq_data_oe_n_o(seq_data_oe_n_o),
        .buffer_one_end_flag_n_o(flag1_n),
        .buffer_two_end_flag_n_o(flag2_n),
        .seq_wr_ready_o(seq_wr_ready_o)
    );

    dsr_seq_model ctl (
        .clk_i(clk_i),
        .seq_o(seq_i)
    );

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ==========
    // closing
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // ceiling well above the roughly 470 cycles the tests need
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            results();
        end
    end

    // ==========
    // notes and watcher
    always @(posedge clk_i) begin
        dsr_note_t n;
        if (look) begin
            n = notes.pop_front();
            `CHK(n.what, n.exp & n.msk, obs & n.msk)
        end
    end

    task automatic note(input string what, input logic [38:0] e, input logic [38:0] m);
        notes.push_back('{what, e, m});
        look = 1'b1;
        @(negedge clk_i);
        look = 1'b0;
        @(negedge clk_i);
    endtask : note

    task automatic chk_rnd(input string what, input logic [1:0] oe, input logic pd, input logic [15:0] d,
                           input logic [15:0] dm);
        note(what, {1'b0, oe, pd, 3'h0, d, 16'h0000}, {1'b0, 2'h3, 1'b1, 3'h0, dm, 16'h0000});
    endtask : chk_rnd

    task automatic chk_seq(input string what, input logic oe, input logic [1:0] f, input logic [15:0] d,
                           input logic [15:0] dm);
        note(what, {4'h0, oe, f, 16'h0000, d}, {4'h0, 1'b1, 2'h3, 16'h0000, dm});
    endtask : chk_seq

    // pins held at least four cycles; a reading host releases data
    task automatic rnd(input logic [5:0] c, input logic [11:0] a, input logic [15:0] d);
        @(negedge clk_i);
        rnd_i = {c, a, c[3] ? ~rnd_i.data : d};
        repeat (4) @(negedge clk_i);
    endtask : rnd

    initial begin
        logic [15:0] r1;
        logic [15:0] r2;
        rnd_i = {IDLE, 12'h000, 16'h0000};
        void'($urandom(86));
        r1 = 16'($urandom);
        r2 = 16'($urandom);
        for (int i = 0; i < 4; i++) begin
            w[i] = 16'($urandom);
        end
        repeat (5) @(negedge clk_i);
        arst_n_i = 1'b1;
        @(negedge clk_i);
        ctrl_reset_n_i = 1'b0;
        @(negedge clk_i);
        ctrl_reset_n_i = 1'b1;
        chk_seq("flags after reset", 1'b1, 2'h3, 16'h0000, 16'h0000);
        rnd(CRD, {9'h000, dsr_pkg::CMD_END1}, 16'h0000);
        chk_rnd("end1 reset", 2'h0, 1'b0, {4'h0, dsr_pkg::RST_END1}, 16'hFFFF);
        rnd(CRD, {9'h000, dsr_pkg::CMD_FLOW}, 16'h0000);
        chk_rnd("flow reset", 2'h0, 1'b0, {12'h000, dsr_pkg::RST_FLOW}, 16'hFFFF);
        $display("test reset done");

        rnd(WR, 12'h101, r1);
        chk_rnd("write quiet", 2'h3, 1'b0, 16'h0000, 16'h0000);
        rnd(WRL, 12'h101, r2);
        rnd(WRN, 12'h101, ~r1);
        chk_rnd("no byte write", 2'h3, 1'b0, 16'h0000, 16'h0000);
        rnd(RD, 12'h101, 16'h0000);
        chk_rnd("read both", 2'h0, 1'b0, {r1[15:8], r2[7:0]}, 16'hFFFF);
        rnd(RDL, 12'h101, 16'h0000);
        chk_rnd("read lower", 2'h2, 1'b0, {8'h00, r2[7:0]}, 16'h00FF);
        rnd(RDU, 12'h101, 16'h0000);
        chk_rnd("read upper", 2'h1, 1'b0, {r1[15:8], 8'h00}, 16'hFF00);
        rnd(RDO, 12'h101, 16'h0000);
        chk_rnd("read oe high", 2'h3, 1'b0, 16'h0000, 16'h0000);
        rnd(6'h30, 12'h101, r2);
        chk_rnd("power down", 2'h3, 1'b1, 16'h0000, 16'h0000);
        rnd(CRD, 12'h006, 16'h0000);
        chk_rnd("reserved read", 2'h0, 1'b0, 16'h0000, 16'hFFFF);
        $display("test random port done");

        rnd(CWR, {9'h000, dsr_pkg::CMD_START1}, 16'hF000);
        rnd(CWR, {9'h000, dsr_pkg::CMD_END1}, 16'hF003);
        rnd(CRD, {9'h000, dsr_pkg::CMD_END1}, 16'h0000);
        chk_rnd("end1 readback", 2'h0, 1'b0, 16'h0003, 16'hFFFF);
        rnd(CWU, {9'h000, dsr_pkg::CMD_END2}, 16'h0A55);
        rnd(CWL, {9'h000, dsr_pkg::CMD_END2}, 16'hFF22);
        rnd(CRD, {9'h000, dsr_pkg::CMD_END2}, 16'h0000);
        chk_rnd("end2 by lanes", 2'h0, 1'b0, 16'h0A22, 16'hFFFF);
        rnd(CWR, {9'h000, dsr_pkg::CMD_FLOW}, 16'h0009);
        rnd(CRD, {9'h000, dsr_pkg::CMD_FLOW}, 16'h0000);
        chk_rnd("flow readback", 2'h0, 1'b0, 16'h0009, 16'hFFFF);
        rnd(IDLE, 12'h000, 16'h0000);
        $display("test command mode done");

        ctl.step(4'h1, w[1]);
        chk_seq("adv write", 1'b1, 2'h3, 16'h0000, 16'h0000);
        ctl.step(4'h1, w[2]);
        ctl.step(4'h1, w[0]);
        chk_seq("end1 by write", 1'b1, 2'h1, 16'h0000, 16'h0000);
        ctl.step(4'h5, w[3]);
        chk_seq("nonadv write", 1'b1, 2'h1, 16'h0000, 16'h0000);
        rnd(CWL, {9'h000, dsr_pkg::CMD_FLAGS}, 16'h0001);
        rnd(IDLE, 12'h000, 16'h0000);
        chk_seq("flag1 cleared", 1'b1, 2'h3, 16'h0000, 16'h0000);
        ctl.step(4'h1, w[0]);
        chk_seq("wrap write", 1'b1, 2'h3, 16'h0000, 16'h0000);
        ctl.step(4'h2, 16'h0000);
        chk_seq("adv read", 1'b0, 2'h3, w[1], 16'hFFFF);
        ctl.step(4'h6, 16'h0000);
        chk_seq("nonadv read", 1'b0, 2'h3, w[1], 16'hFFFF);
        ctl.step(4'h3, 16'h0000);
        chk_seq("read oe high", 1'b1, 2'h3, 16'h0000, 16'h0000);
        ctl.step(4'h2, 16'h0000);
        chk_seq("read at end1", 1'b0, 2'h1, w[3], 16'hFFFF);
        ctl.step(4'hE, 16'h0000);
        chk_seq("deselect hold", 1'b1, 2'h1, 16'h0000, 16'h0000);
        ctl.step(4'hA, 16'h0000);
        chk_seq("deselect adv", 1'b1, 2'h1, 16'h0000, 16'h0000);
        ctl.step(4'h2, 16'h0000);
        chk_seq("wrapped read", 1'b0, 2'h1, w[1], 16'hFFFF);
        $display("test sequential port done");

        // a held random write stalls the drain, so the fifo fills
        rnd(WR, 12'h200, r1);
        for (int i = 0; i < 9; i++) begin
            ctl.step(4'h1, 16'($urandom));
        end
        note("fifo full", {1'b0, 38'h0}, {1'b1, 38'h0});
        rnd(IDLE, 12'h000, 16'h0000);
        repeat (20) @(negedge clk_i);
        note("fifo drained", {1'b1, 38'h0}, {1'b1, 38'h0});
        $display("test write buffer done");
        rnd(CWR, {9'h000, dsr_pkg::CMD_START2}, 16'h0004);
        rnd(CWR, {9'h000, dsr_pkg::CMD_END2}, 16'h0005);
        // buffer one chains into buffer two, buffer two stops at its end
        rnd(CWR, {9'h000, dsr_pkg::CMD_FLOW}, 16'h0008);
        rnd(CWL, {9'h000, dsr_pkg::CMD_FLAGS}, 16'h0003);
        rnd(IDLE, 12'h000, 16'h0000);
        ctl.step(4'h1, w[2]);
        chk_seq("end1 again", 1'b1, 2'h1, 16'h0000, 16'h0000);
        ctl.step(4'h1, w[3]);
        chk_seq("chain to start2", 1'b1, 2'h1, 16'h0000, 16'h0000);
        ctl.step(4'h1, r1);
        chk_seq("end2 by write", 1'b1, 2'h0, 16'h0000, 16'h0000);
        ctl.step(4'h2, 16'h0000);
        chk_seq("stop at end2", 1'b0, 2'h0, r1, 16'hFFFF);
        rnd(CRD, {9'h000, dsr_pkg::CMD_FLAGS}, 16'h0000);
        chk_rnd("flag status", 2'h0, 1'b0, 16'h0003, 16'hFFFF);
        $display("test buffer flow done");
        results();
    end
endmodule : dsr_ports_bench

`undef CHK
`default_nettype wire
